/* File: core/bca_exec.sv */
// Module: byte ALU execution block with a classic Wishbone register slave.
//
// Notes on behaviour
// - Adding work to file sums the working register and file register 0 to 127, updating C, DC, Z.
// - For add, add with carry and shift, destination 0 writes W and 1 writes the file register.
// - The arithmetic shift moves bits toward bit 0, keeps bit 7, puts old bit 0 in C, updates Z.
// - Add with carry sums W, the file register and the carry flag, updating C, DC and Z.
// - Bit clear zeroes the selected bit 0 to 7 and leaves other bits and all flags alone.
// - Bit test skips the next instruction with a one-cycle no_operation when the bit is zero.
// - The relative jump loads the incremented program counter plus a signed 9-bit offset.
// - The relative jump always takes two instruction cycles.
// - A counter change or a true test costs two cycles, the second being a no_operation.
//
// Our own choices: the Wishbone register port and the address map.
module bca_exec
  import bca_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  bca_state_e  state_reg;
  bca_state_e  state_next;
  logic [31:0] insn_word_reg;
  logic [7:0]  w_reg;
  logic [14:0] pc_reg;
  logic        c_reg;
  logic        dc_reg;
  logic        z_reg;
  logic [1:0]  cyc_reg;
  logic [7:0]  file_reg [128];
  logic        ack_reg;
  logic [31:0] dat_reg;

  wire logic        idle;
  wire logic        exec;
  wire logic        bus_req;
  wire logic        bus_wr;
  wire logic        hit_insn;
  wire logic        hit_wreg;
  wire logic        hit_status;
  wire logic        hit_pc;
  wire logic        hit_cyc;
  wire logic        hit_file;
  wire logic [6:0]  file_idx;
  wire logic [31:0] rd_data;
  wire logic [31:0] wr_word;
  wire bca_insn_s   insn;
  wire logic [7:0]  f_sel;
  bca_alu_s         alu;
  wire logic        is_jump;
  wire logic        skip;
  wire logic        two_cycle;
  wire logic [14:0] pc_inc;
  wire logic [14:0] pc_exec;

  // Sequencer state decode.
  assign idle = state_reg == BCA_S_IDLE;
  assign exec = state_reg == BCA_S_EXEC;

  // The bus is served only while idle, so software never races execution.
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg & idle;
  assign bus_wr  = bus_req & wb_we_i;

  // Address decode; anything else is acked, reads zero and ignores writes.
  assign hit_insn   = wb_adr_i == BCA_ADR_INSN;
  assign hit_wreg   = wb_adr_i == BCA_ADR_WREG;
  assign hit_status = wb_adr_i == BCA_ADR_STATUS;
  assign hit_pc     = wb_adr_i == BCA_ADR_PC;
  assign hit_cyc    = wb_adr_i == BCA_ADR_CYC;
  assign hit_file   = (wb_adr_i[11:9] == BCA_FILE_SEL) & (wb_adr_i[1:0] == 2'h0);
  assign file_idx   = wb_adr_i[8:2];

  // Read data select and byte-lane merge for writes.
  assign rd_data = hit_insn   ? insn_word_reg :
                   hit_wreg   ? {24'h000000, w_reg} :
                   hit_status ? {29'h0, z_reg, dc_reg, c_reg} :
                   hit_pc     ? {17'h0, pc_reg} :
                   hit_cyc    ? {30'h0, cyc_reg} :
                   hit_file   ? {24'h000000, file_reg[file_idx]} :
                   32'h00000000;
  assign wr_word = bca_merge(rd_data, wb_dat_i, wb_sel_i);

  // Instruction fields and the addressed file register operand.
  assign insn  = bca_decode(insn_word_reg);
  assign f_sel = file_reg[insn.faddr];

  // Datapath.
  bca_alu u_alu (
    .insn_i (insn),
    .w_i    (w_reg),
    .f_i    (f_sel),
    .c_i    (c_reg),
    .alu_o  (alu)
  );

  // Program counter and cycle count of the running instruction.
  assign is_jump   = insn.op == BCA_RELATIVE_JUMP;
  assign skip      = (insn.op == BCA_BIT_TEST_SKIP_IF_ZERO) & ~alu.tbit;
  assign two_cycle = is_jump | skip;
  assign pc_inc    = pc_reg + BCA_PC_STEP;
  assign pc_exec   = is_jump ? pc_inc + {{6{insn.k[8]}}, insn.k} :
                     skip    ? pc_reg + BCA_PC_SKIP :
                     pc_inc;

  // Next state: a write to the instruction register starts execution.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BCA_S_IDLE: begin
        if (bus_wr & hit_insn) begin
          state_next = BCA_S_EXEC;
        end
      end
      BCA_S_EXEC: begin
        state_next = two_cycle ? BCA_S_NOP : BCA_S_IDLE;
      end
      BCA_S_NOP: begin
        state_next = BCA_S_IDLE;
      end
      default: begin
        state_next = BCA_S_IDLE;
      end
    endcase
  end

  // Sequencer state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= BCA_S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Instruction register and last cycle count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      insn_word_reg <= BCA_INSN_RST;
      cyc_reg       <= BCA_CYC_RST;
    end else begin
      if (bus_wr & hit_insn) begin
        insn_word_reg <= wr_word;
      end
      if (exec) begin
        cyc_reg <= two_cycle ? BCA_CYC_DOUBLE : BCA_CYC_SINGLE;
      end
    end
  end

  // Working register and program counter.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_reg  <= BCA_W_RST;
      pc_reg <= BCA_PC_RST;
    end else if (exec) begin
      if (alu.to_w) begin
        w_reg <= alu.res;
      end
      pc_reg <= pc_exec;
    end else begin
      if (bus_wr & hit_wreg) begin
        w_reg <= wr_word[7:0];
      end
      if (bus_wr & hit_pc) begin
        pc_reg <= wr_word[14:0];
      end
    end
  end

  // Status flags; bit clear, bit test and jump leave them alone.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_reg  <= BCA_FLAG_RST;
      dc_reg <= BCA_FLAG_RST;
      z_reg  <= BCA_FLAG_RST;
    end else if (exec) begin
      if (alu.upd_cz) begin
        c_reg <= alu.c;
        z_reg <= alu.z;
      end
      if (alu.upd_dc) begin
        dc_reg <= alu.dc;
      end
    end else if (bus_wr & hit_status) begin
      c_reg  <= wr_word[BCA_STAT_C];
      dc_reg <= wr_word[BCA_STAT_DC];
      z_reg  <= wr_word[BCA_STAT_Z];
    end
  end

  // File registers, written by execution or by the bus when idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 128; i++) begin
        file_reg[i] <= BCA_FILE_RST;
      end
    end else if (exec & alu.to_file) begin
      file_reg[insn.faddr] <= alu.res;
    end else if (bus_wr & hit_file) begin
      file_reg[file_idx] <= wr_word[7:0];
    end
  end

  // Bus answer: one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        dat_reg <= rd_data;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Reference sums built independently of the datapath for checking.
  wire logic [8:0]  ref_sum;
  wire logic [4:0]  ref_nib;
  wire logic [14:0] ref_jump;
  assign ref_sum  = {1'b0, w_reg} + {1'b0, f_sel} +
                    {8'h00, c_reg & (insn.op == BCA_ADD_WORK_FILE_WITH_CARRY)};
  assign ref_nib  = {1'b0, w_reg[3:0]} + {1'b0, f_sel[3:0]};
  assign ref_jump = pc_reg + BCA_PC_STEP + {{6{insn.k[8]}}, insn.k};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  add_to_work_a: assert property (
    exec && insn.op == BCA_ADD_WORK_TO_FILE && !insn.dest
    |=> w_reg == $past(ref_sum[7:0]) && c_reg == $past(ref_sum[8]))
    else $error("add to W gave a wrong sum or carry");

  add_to_file_a: assert property (
    exec && insn.op == BCA_ADD_WORK_TO_FILE && insn.dest
    |=> file_reg[$past(insn.faddr)] == $past(ref_sum[7:0]) && $stable(w_reg))
    else $error("add to file did not land in the file register");

  add_carry_in_a: assert property (
    exec && insn.op == BCA_ADD_WORK_FILE_WITH_CARRY
    |=> c_reg == $past(ref_sum[8]) && z_reg == ($past(ref_sum[7:0]) == 8'h00))
    else $error("add with carry flags wrong");

  shift_carry_a: assert property (
    exec && insn.op == BCA_ARITH_SHIFT_RIGHT_FILE && !insn.dest
    |=> c_reg == $past(f_sel[0]) && w_reg == {$past(f_sel[7]), $past(f_sel[7:1])}
        && $stable(dc_reg))
    else $error("arithmetic shift result or carry wrong");

  bit_clear_a: assert property (
    exec && insn.op == BCA_BIT_CLEAR_FILE
    |=> $stable({c_reg, dc_reg, z_reg}) && !file_reg[$past(insn.faddr)][$past(insn.bit_sel)])
    else $error("bit clear missed the bit or touched flags");

  bit_clear_rest_a: assert property (
    exec && insn.op == BCA_BIT_CLEAR_FILE
    |=> (file_reg[$past(insn.faddr)] | (8'h01 << $past(insn.bit_sel)))
        == ($past(f_sel) | (8'h01 << $past(insn.bit_sel))))
    else $error("bit clear disturbed another bit");

  skip_taken_a: assert property (
    exec && insn.op == BCA_BIT_TEST_SKIP_IF_ZERO && !f_sel[insn.bit_sel]
    |=> state_reg == BCA_S_NOP && pc_reg == $past(pc_reg) + BCA_PC_SKIP ##1 idle)
    else $error("zero bit test did not skip");

  skip_not_taken_a: assert property (
    exec && insn.op == BCA_BIT_TEST_SKIP_IF_ZERO && f_sel[insn.bit_sel]
    |=> idle && pc_reg == $past(pc_reg) + BCA_PC_STEP && $stable({c_reg, dc_reg, z_reg}))
    else $error("set bit test did not run on");

  jump_target_a: assert property (
    exec && is_jump |=> pc_reg == $past(ref_jump) && $stable({c_reg, dc_reg, z_reg}))
    else $error("relative jump target wrong");

  jump_two_cycle_a: assert property (
    exec && is_jump |=> state_reg == BCA_S_NOP && cyc_reg == BCA_CYC_DOUBLE ##1 idle)
    else $error("relative jump not two cycles");

  nop_cycle_a: assert property (
    state_reg == BCA_S_NOP
    |=> idle && $stable({w_reg, pc_reg, c_reg, dc_reg, z_reg}))
    else $error("second cycle was not a no_operation");

  single_cycle_a: assert property (
    exec && !is_jump && !(insn.op == BCA_BIT_TEST_SKIP_IF_ZERO && !f_sel[insn.bit_sel])
    |=> idle && cyc_reg == BCA_CYC_SINGLE)
    else $error("one-cycle instruction took an extra cycle");

  nibble_carry_a: assert property (
    exec && insn.op == BCA_ADD_WORK_TO_FILE
    |=> dc_reg == $past(ref_nib[4]) && z_reg == ($past(ref_sum[7:0]) == 8'h00))
    else $error("nibble carry or zero flag wrong");

endmodule

/* File: core/bca_pkg.sv */
// Package: constants, types and helpers of the byte ALU execution block.
package bca_pkg;

  // Register byte addresses on the bus.
  localparam logic [11:0] BCA_ADR_INSN   = 12'h000;
  localparam logic [11:0] BCA_ADR_WREG   = 12'h004;
  localparam logic [11:0] BCA_ADR_STATUS = 12'h008;
  localparam logic [11:0] BCA_ADR_PC     = 12'h00C;
  localparam logic [11:0] BCA_ADR_CYC    = 12'h010;
  // File registers sit in the window 0x200 to 0x3FC, one per word.
  localparam logic [2:0]  BCA_FILE_SEL   = 3'h1;

  // Instruction word field positions.
  localparam int BCA_OP_LSB   = 0;
  localparam int BCA_DEST_POS = 3;
  localparam int BCA_BIT_LSB  = 4;
  localparam int BCA_FILE_LSB = 8;
  localparam int BCA_K_LSB    = 16;

  // Status word field positions.
  localparam int BCA_STAT_C  = 0;
  localparam int BCA_STAT_DC = 1;
  localparam int BCA_STAT_Z  = 2;

  // Reset values.
  localparam logic [31:0] BCA_INSN_RST = 32'h0000_0000;
  localparam logic [7:0]  BCA_W_RST    = 8'h00;
  localparam logic [7:0]  BCA_FILE_RST = 8'h00;
  localparam logic [14:0] BCA_PC_RST   = 15'h0000;
  localparam logic        BCA_FLAG_RST = 1'b0;
  localparam logic [1:0]  BCA_CYC_RST  = 2'h0;

  // Timing counts and program counter steps.
  localparam logic [1:0]  BCA_CYC_SINGLE = 2'h1;
  localparam logic [1:0]  BCA_CYC_DOUBLE = 2'h2;
  localparam logic [14:0] BCA_PC_STEP    = 15'h0001;
  localparam logic [14:0] BCA_PC_SKIP    = 15'h0002;

  // Operation codes; code 7 is treated as no_operation.
  typedef enum logic [2:0] {
    BCA_ADD_WORK_TO_FILE         = 3'h0,
    BCA_ADD_WORK_FILE_WITH_CARRY = 3'h1,
    BCA_ARITH_SHIFT_RIGHT_FILE   = 3'h2,
    BCA_BIT_CLEAR_FILE           = 3'h3,
    BCA_BIT_TEST_SKIP_IF_ZERO    = 3'h4,
    BCA_RELATIVE_JUMP            = 3'h5,
    BCA_NO_OPERATION             = 3'h6
  } bca_op_e;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    BCA_S_IDLE = 3'b001,
    BCA_S_EXEC = 3'b010,
    BCA_S_NOP  = 3'b100
  } bca_state_e;

  // Decoded instruction.
  typedef struct packed {
    bca_op_e    op;
    logic       dest;
    logic [2:0] bit_sel;
    logic [6:0] faddr;
    logic [8:0] k;
  } bca_insn_s;

  // Datapath result with flag values and write enables.
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       dc;
    logic       z;
    logic       tbit;
    logic       to_w;
    logic       to_file;
    logic       upd_cz;
    logic       upd_dc;
  } bca_alu_s;

  // Splits an instruction word into its fields.
  function automatic bca_insn_s bca_decode(input logic [31:0] word);
    bca_insn_s d;
    d.op      = bca_op_e'(word[BCA_OP_LSB +: 3]);
    d.dest    = word[BCA_DEST_POS];
    d.bit_sel = word[BCA_BIT_LSB +: 3];
    d.faddr   = word[BCA_FILE_LSB +: 7];
    d.k       = word[BCA_K_LSB +: 9];
    return d;
  endfunction

  // Replaces the byte lanes of a word that the select bits enable.
  function automatic logic [31:0] bca_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m;
  endfunction

endpackage

/* File: core/bca_alu.sv */
// Module: combinational byte datapath for add, shift, bit clear and bit test.
module bca_alu
  import bca_pkg::*;
(
  // Instruction and operands.
  input  wire bca_insn_s  insn_i,
  input  wire logic [7:0] w_i,
  input  wire logic [7:0] f_i,
  input  wire logic       c_i,
  // Result, flags and write enables.
  output bca_alu_s        alu_o
);

  wire logic       is_addc;
  wire logic       is_add;
  wire logic       is_asr;
  wire logic       is_bclr;
  wire logic       carry_in;
  wire logic [8:0] sum9;
  wire logic [4:0] low5;
  wire logic [7:0] res;

  // Operation class decode.
  assign is_addc  = insn_i.op == BCA_ADD_WORK_FILE_WITH_CARRY;
  assign is_add   = (insn_i.op == BCA_ADD_WORK_TO_FILE) | is_addc;
  assign is_asr   = insn_i.op == BCA_ARITH_SHIFT_RIGHT_FILE;
  assign is_bclr  = insn_i.op == BCA_BIT_CLEAR_FILE;
  assign carry_in = is_addc & c_i;

  // Full sum and low nibble sum, the latter giving the nibble carry.
  assign sum9 = {1'b0, w_i} + {1'b0, f_i} + {8'h00, carry_in};
  assign low5 = {1'b0, w_i[3:0]} + {1'b0, f_i[3:0]} + {4'h0, carry_in};

  // Result select; the shift keeps the top bit in place.
  assign res = is_add  ? sum9[7:0] :
               is_asr  ? {f_i[7], f_i[7:1]} :
               is_bclr ? (f_i & ~(8'h01 << insn_i.bit_sel)) :
               f_i;

  // Flags and destination enables.
  assign alu_o = '{
    res:     res,
    c:       is_asr ? f_i[0] : sum9[8],
    dc:      low5[4],
    z:       res == 8'h00,
    tbit:    f_i[insn_i.bit_sel],
    to_w:    (is_add | is_asr) & ~insn_i.dest,
    to_file: ((is_add | is_asr) & insn_i.dest) | is_bclr,
    upd_cz:  is_add | is_asr,
    upd_dc:  is_add
  };

endmodule

/* File: verification/bca_exec_tb.sv */
// Testbench: drives the byte ALU execution block over Wishbone and checks its results.
module bca_exec_tb
  import bca_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;

  // Design stimulus and observed outputs.
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  // Bench bookkeeping.
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          cycle_cnt  = 0;
  logic [14:0] pc_exp;

  // Clock of 8 ns period.
  always #4 clk_i = ~clk_i;

  // Device under test.
  bca_exec DUT (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one and reports a difference.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask

  // One classic Wishbone cycle; the request is held until ack is sampled high.
  // A missing ack is ended by the bench timeout, not here.
  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] wdat,
                         output logic [31:0] rdat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wdat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Register write.
  task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    logic [31:0] dummy;
    wb_xfer(1'b1, adr, dat, dummy);
  endtask

  // Register read compared with an expected value.
  task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    logic [31:0] rdat;
    wb_xfer(1'b0, adr, 32'h0000_0000, rdat);
    check(rdat, exp);
  endtask

  // Byte address of file register n.
  function automatic logic [11:0] fadr(input logic [6:0] n);
    return 12'h200 + {3'h0, n, 2'h0};
  endfunction

  // Starts one instruction by writing the instruction word.
  task automatic exec(input logic [2:0] op, input logic dest, input logic [2:0] bsel,
                      input logic [6:0] fa, input logic [8:0] k);
    wr(BCA_ADR_INSN, {7'h00, k, 1'b0, fa, 1'b0, bsel, dest, op});
  endtask

  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cycle_cnt++;
    if (cycle_cnt >= 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state and an unmapped address that reads zero and ignores writes.
    rd_chk(BCA_ADR_WREG, 32'h0000_0000);
    rd_chk(BCA_ADR_STATUS, 32'h0000_0000);
    rd_chk(BCA_ADR_PC, 32'h0000_0000);
    rd_chk(fadr(7'h7F), 32'h0000_0000);
    wr(12'h100, 32'hFFFF_FFFF);
    rd_chk(12'h100, 32'h0000_0000);
    // Addition into W on the top file address, carry out of the low nibble only.
    wr(BCA_ADR_WREG, 32'h0000_000F);
    wr(fadr(7'h7F), 32'h0000_0001);
    exec(BCA_ADD_WORK_TO_FILE, 1'b0, 3'h0, 7'h7F, 9'h000);
    rd_chk(BCA_ADR_WREG, 32'h0000_0010);
    rd_chk(BCA_ADR_STATUS, 32'h0000_0002);
    rd_chk(fadr(7'h7F), 32'h0000_0001);
    rd_chk(BCA_ADR_PC, 32'h0000_0001);
    rd_chk(BCA_ADR_CYC, 32'h0000_0001);
    // Addition back into the file register with carry out and zero result.
    wr(BCA_ADR_WREG, 32'h0000_0080);
    wr(fadr(7'h03), 32'h0000_0080);
    exec(BCA_ADD_WORK_TO_FILE, 1'b1, 3'h0, 7'h03, 9'h000);
    rd_chk(fadr(7'h03), 32'h0000_0000);
    rd_chk(BCA_ADR_WREG, 32'h0000_0080);
    rd_chk(BCA_ADR_STATUS, 32'h0000_0005);
    // Addition with the carry set: the carry-in completes a wrap to zero.
    wr(BCA_ADR_WREG, 32'h0000_0001);
    wr(fadr(7'h09), 32'h0000_00FE);
    exec(BCA_ADD_WORK_FILE_WITH_CARRY, 1'b1, 3'h0, 7'h09, 9'h000);
    rd_chk(fadr(7'h09), 32'h0000_0000);
    rd_chk(BCA_ADR_STATUS, 32'h0000_0007);
    // Addition with the carry clear, result to W.
    wr(BCA_ADR_STATUS, 32'h0000_0000);
    wr(BCA_ADR_WREG, 32'h0000_0011);
    wr(fadr(7'h09), 32'h0000_0022);
    exec(BCA_ADD_WORK_FILE_WITH_CARRY, 1'b0, 3'h0, 7'h09, 9'h000);
    rd_chk(BCA_ADR_WREG, 32'h0000_0033);
    rd_chk(BCA_ADR_STATUS, 32'h0000_0000);
    // Arithmetic shift keeps the top bit, old bit 0 goes to carry, nibble carry untouched.
    wr(BCA_ADR_STATUS, 32'h0000_0002);
    wr(fadr(7'h04), 32'h0000_0081);
    exec(BCA_ARITH_SHIFT_RIGHT_FILE, 1'b1, 3'h0, 7'h04, 9'h000);
    rd_chk(fadr(7'h04), 32'h0000_00C0);
    rd_chk(BCA_ADR_STATUS, 32'h0000_0003);
    wr(fadr(7'h05), 32'h0000_0001);
    exec(BCA_ARITH_SHIFT_RIGHT_FILE, 1'b0, 3'h0, 7'h05, 9'h000);
    rd_chk(BCA_ADR_WREG, 32'h0000_0000);
    rd_chk(fadr(7'h05), 32'h0000_0001);
    rd_chk(BCA_ADR_STATUS, 32'h0000_0007);
    // Bit clear on every position, flags and other bits left alone.
    for (int b = 0; b < 8; b++) begin
      wr(fadr(7'h06), 32'h0000_00FF);
      exec(BCA_BIT_CLEAR_FILE, 1'b0, b[2:0], 7'h06, 9'h000);
      rd_chk(fadr(7'h06), {24'h0, 8'hFF ^ (8'h01 << b)});
      rd_chk(BCA_ADR_STATUS, 32'h0000_0007);
      rd_chk(BCA_ADR_CYC, 32'h0000_0001);
    end
    // Bit test on a mixed pattern: a clear bit skips and costs two cycles.
    wr(fadr(7'h07), 32'h0000_00A5);
    for (int b = 0; b < 8; b++) begin
      wr(BCA_ADR_PC, 32'h0000_0010);
      exec(BCA_BIT_TEST_SKIP_IF_ZERO, 1'b0, b[2:0], 7'h07, 9'h000);
      pc_exp = ((8'hA5 >> b) & 8'h01) != 8'h00 ? 15'h0011 : 15'h0012;
      rd_chk(BCA_ADR_PC, {17'h0, pc_exp});
      rd_chk(BCA_ADR_CYC, pc_exp == 15'h0011 ? 32'h1 : 32'h2);
      rd_chk(BCA_ADR_STATUS, 32'h0000_0007);
    end
    // Relative jump over the offset extremes and small values.
    for (int i = 0; i < 4; i++) begin
      logic [8:0] k;
      k = (i == 0) ? 9'h100 : (i == 1) ? 9'h0FF : (i == 2) ? 9'h000 : 9'h1FF;
      wr(BCA_ADR_PC, 32'h0000_0200);
      exec(BCA_RELATIVE_JUMP, 1'b0, 3'h0, 7'h00, k);
      pc_exp = 15'h0201 + {{6{k[8]}}, k};
      rd_chk(BCA_ADR_PC, {17'h0, pc_exp});
      rd_chk(BCA_ADR_CYC, 32'h0000_0002);
      rd_chk(BCA_ADR_STATUS, 32'h0000_0007);
    end
    // Both no-operation codes step the counter by one in one cycle.
    for (int op = 6; op < 8; op++) begin
      wr(BCA_ADR_PC, 32'h0000_0030);
      exec(op[2:0], 1'b0, 3'h0, 7'h00, 9'h000);
      rd_chk(BCA_ADR_PC, 32'h0000_0031);
      rd_chk(BCA_ADR_CYC, 32'h0000_0001);
    end
    // A second reset in mid-run returns the registers to their reset values.
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(BCA_ADR_PC, 32'h0000_0000);
    rd_chk(BCA_ADR_STATUS, 32'h0000_0000);
    rd_chk(BCA_ADR_CYC, 32'h0000_0000);
    rd_chk(fadr(7'h04), 32'h0000_0000);
    finish_test();
  end
endmodule
